// ==== exposure_status_consts.svh ====
// Purpose: Offsets, field positions and reset values of the exposure status block
// Assumes: Nine-bit register index of the serial register access path
// Notes: Definitions only, no logic
`ifndef EXPOSURE_STATUS_CONSTS_SVH
`define EXPOSURE_STATUS_CONSTS_SVH

// Controller-side status words
`define OFS_STATS_PIXEL_COUNT 9'h0b8
`define OFS_FRAME_MEAN_LEVEL 9'h0ba
`define OFS_COMPUTED_INTEGRATION 9'h0bb
`define OFS_COMPUTED_GAINS 9'h0bc

// Sequencer-side status words
`define OFS_APPLIED_STEP_GRANULARITY 9'h0d0
`define OFS_APPLIED_ARRAY_CLEAR_SPAN 9'h0d1
`define OFS_APPLIED_INTEGRATION 9'h0d2
`define OFS_APPLIED_SECOND_KNEE_TIME 9'h0d3
`define OFS_APPLIED_THIRD_KNEE_TIME 9'h0d4
`define OFS_APPLIED_ANALOG_GAINS 9'h0d5
`define OFS_APPLIED_FINE_GAIN_AND_KNEES 9'h0d6

// Monitor selector word and its field
`define OFS_MONITOR_CONFIG 9'h0c0
`define MONITOR_SEL_LSB 11
`define MONITOR_SEL_MSB 13
`define MONITOR_SEL_RESET 3'h0

// Temperature words
`define OFS_JUNCTION_TEMP_COUNT 9'h0e8
`define OFS_THERMAL_PROBE_ON 9'h0e9
`define THERMAL_PROBE_ON_RESET 1'h0
`define TEMP_COUNT_RESET 8'h00

// Field positions in the packed gain words
`define CGAIN_AFE_LSB 2
`define CGAIN_DIG_LSB 4
`define AGAIN_AFE_LSB 5
`define FGAIN_DUAL_BIT 12
`define FGAIN_TRIPLE_BIT 13

// Status words come out of reset as zero
`define STATUS_RESET 16'h0000

`endif

// ==== exposure_status_pkg.sv ====
// Purpose: Types shared by the exposure status block
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in the header, only types here
package exposure_status_pkg;

  // Monitor output assignment codes
  typedef enum logic [2:0] {
    mon_off = 3'b000,
    mon_integ_rot = 3'b001,
    mon_integ_knee = 3'b010,
    mon_xro_black = 3'b011,
    mon_frame_rot = 3'b100,
    mon_first_rot = 3'b101,
    mon_rot_xro = 3'b110,
    mon_black_image = 3'b111
  } monitor_sel_t;

endpackage : exposure_status_pkg

// ==== thermal_probe_ctl.sv ====
// Purpose: Run and reset control of the junction temperature sensor
// Assumes: Converter code is valid only while its valid strobe is high
// Notes: Count is forced to zero whenever the probe is off
`timescale 1ns/1ps
`include "exposure_status_consts.svh"

module thermal_probe_ctl (
  input wire logic clk,
  input wire logic reset,
  input wire logic probe_on, // Software enable, high runs the sensor
  input wire logic [7:0] temp_code, // Raw count from the converter
  input wire logic temp_code_valid, // One-cycle strobe with a new count
  output logic temp_sensor_enable, // Run control to the sensor
  output logic temp_sensor_reset_n, // Low holds the sensor in reset
  output logic [7:0] junction_temp_count // Latest count, zero when off
);

  // Run and reset follow the enable; both drop together
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      temp_sensor_enable <= 1'b0;
      temp_sensor_reset_n <= 1'b0;
    end else begin
      temp_sensor_enable <= probe_on;
      temp_sensor_reset_n <= probe_on;
    end
  end

  // Count tracks the converter; a stale reading would mislead after a restart
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      junction_temp_count <= `TEMP_COUNT_RESET;
    end else if (!probe_on) begin
      junction_temp_count <= `TEMP_COUNT_RESET;
    end else if (temp_code_valid && temp_sensor_enable) begin
      junction_temp_count <= temp_code;
    end
  end

  a_probe_off_clears: assert property (@(posedge clk) disable iff (reset)
    !probe_on |=> junction_temp_count == 8'h00 && !temp_sensor_enable
      && !temp_sensor_reset_n)
    else $error("temperature sensor not held off while disabled");

endmodule : thermal_probe_ctl

// ==== monitor_route.sv ====
// Purpose: Routes internal sequencer states to the two monitor pins
// Assumes: State inputs are synchronous single-bit levels or pulses
// Notes: Outputs are registered, so they trail the states by one cycle
`timescale 1ns/1ps

module monitor_route (
  input wire logic clk,
  input wire logic reset,
  input wire exposure_status_pkg::monitor_sel_t sel, // Assignment code
  input wire logic integration_time, // High while integrating
  input wire logic row_overhead_time, // High during row overhead time
  input wire logic row_overhead_start, // Start of row overhead time
  input wire logic knee_sequence, // High during dual/triple slope sequence
  input wire logic xro_start, // Start of x-readout
  input wire logic black_line, // High during black lines
  input wire logic frame_start, // Frame start indication
  input wire logic first_line, // High during the first line
  input wire logic xro_black_start, // Start of x-readout for black lines
  input wire logic xro_image_start, // Start of x-readout for image lines
  output logic monitor0, // First monitor pin
  output logic monitor1 // Second monitor pin
);

  // One selector per pin; all eight codes are legal so no default
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      monitor0 <= 1'b0;
      monitor1 <= 1'b0;
    end else begin
      unique case (sel)
        exposure_status_pkg::mon_off: begin
          monitor0 <= 1'b0;
          monitor1 <= 1'b0;
        end
        exposure_status_pkg::mon_integ_rot: begin
          monitor0 <= integration_time;
          monitor1 <= row_overhead_time;
        end
        exposure_status_pkg::mon_integ_knee: begin
          monitor0 <= integration_time;
          monitor1 <= knee_sequence;
        end
        exposure_status_pkg::mon_xro_black: begin
          monitor0 <= xro_start;
          monitor1 <= black_line;
        end
        exposure_status_pkg::mon_frame_rot: begin
          monitor0 <= frame_start;
          monitor1 <= row_overhead_start;
        end
        exposure_status_pkg::mon_first_rot: begin
          monitor0 <= first_line;
          monitor1 <= row_overhead_start;
        end
        exposure_status_pkg::mon_rot_xro: begin
          monitor0 <= row_overhead_time;
          monitor1 <= xro_start;
        end
        exposure_status_pkg::mon_black_image: begin
          monitor0 <= xro_black_start;
          monitor1 <= xro_image_start;
        end
      endcase
    end
  end

  a_code4_route: assert property (@(posedge clk) disable iff (reset)
    sel == exposure_status_pkg::mon_frame_rot |=> monitor0 == $past(frame_start)
      && monitor1 == $past(row_overhead_start))
    else $error("monitor code 4 routes wrong states");

endmodule : monitor_route

// ==== exposure_status_and_temp_readout.sv ====
// Purpose: Exposure status words, temperature readout and monitor routing
// Assumes: Register access path gives a nine-bit index and one-cycle strobes
// Notes: Read data appears one cycle after the read strobe, with a valid pulse
`timescale 1ns/1ps
`include "exposure_status_consts.svh"

// Overview of operation
// - Controller words refresh on each sequencer request
// - Sequencer words refresh only when applied
// - Report 16-bit statistics pixel count
// - Report 10-bit frame mean level
// - Report computed integration and three gains
// - Report applied integration step granularity
// - Report applied array reset length
// - Report applied integration and both knee times
// - Report applied analog and fine gains
// - Report dual and triple slope flags
// - Provide 8-bit junction temperature count
// - Temperature count readable over register path
// - Enable runs sensor; low disables and resets
// - Two monitor pins, three-bit assignment code
// - Code 4 gives frame start, ROW_OVERHEAD_TIME start
module exposure_status_and_temp_readout (
  input wire logic clk,
  input wire logic reset,
  // Register access path
  input wire logic [8:0] reg_addr, // Register index
  input wire logic reg_wr, // One-cycle write strobe
  input wire logic reg_rd, // One-cycle read strobe
  input wire logic [15:0] reg_wdata, // Write data
  output logic [15:0] reg_rdata, // Read data, held until next read
  output logic reg_rvalid, // One-cycle pulse with read data
  // Values computed by the exposure controller
  input wire logic aec_request, // Pulse: values handed to sequencer
  input wire logic [15:0] aec_pixel_count,
  input wire logic [9:0] aec_mean_level,
  input wire logic [15:0] aec_integration,
  input wire logic [1:0] aec_mux_gain,
  input wire logic [1:0] aec_afe_gain,
  input wire logic [11:0] aec_digital_gain,
  // Values taking effect on readout
  input wire logic seq_apply, // Pulse: values now in effect
  input wire logic [15:0] seq_step_granularity,
  input wire logic [15:0] seq_clear_span,
  input wire logic [15:0] seq_integration,
  input wire logic [15:0] seq_second_knee_time,
  input wire logic [15:0] seq_third_knee_time,
  input wire logic [4:0] seq_mux_gain,
  input wire logic [7:0] seq_afe_gain,
  input wire logic [11:0] seq_fine_gain,
  input wire logic seq_dual_slope,
  input wire logic seq_triple_slope,
  // Temperature converter
  input wire logic [7:0] temp_code,
  input wire logic temp_code_valid,
  output logic temp_sensor_enable,
  output logic temp_sensor_reset_n,
  // Sequencer states for the monitor pins
  input wire logic integration_time,
  input wire logic row_overhead_time,
  input wire logic row_overhead_start,
  input wire logic knee_sequence,
  input wire logic xro_start,
  input wire logic black_line,
  input wire logic frame_start,
  input wire logic first_line,
  input wire logic xro_black_start,
  input wire logic xro_image_start,
  output logic monitor0,
  output logic monitor1
);

  // Controller-side status words
  logic [15:0] stats_pixel_count; // Pixels taken into statistics
  logic [9:0] frame_mean_level; // Mean illumination of the frame
  logic [15:0] computed_integration; // Requested integration
  logic [1:0] computed_mux_gain; // Requested first-stage gain
  logic [1:0] computed_afe_gain; // Requested second-stage gain
  logic [11:0] computed_digital_gain; // Requested digital gain, 5.7

  // Sequencer-side status words
  logic [15:0] applied_step_granularity; // Global shutter only
  logic [15:0] applied_array_clear_span; // Global shutter only
  logic [15:0] applied_integration;
  logic [15:0] applied_second_knee_time;
  logic [15:0] applied_third_knee_time;
  logic [4:0] applied_mux_gain;
  logic [7:0] applied_afe_gain;
  logic [11:0] applied_fine_gain; // 5.7 unsigned
  logic applied_dual_slope;
  logic applied_triple_slope;

  // Writable configuration and the read-only temperature count
  exposure_status_pkg::monitor_sel_t monitor_sel; // Monitor assignment code
  logic thermal_probe_on; // Temperature sensor enable
  logic [7:0] junction_temp_count; // From the probe control

  // Decodes a write strobe to one index
  function automatic logic write_hit(input logic wr, input logic [8:0] addr,
                                     input logic [8:0] target);
    write_hit = wr && (addr == target);
  endfunction : write_hit

  // Controller words latch together on the request, so a read never mixes frames
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stats_pixel_count <= `STATUS_RESET;
      frame_mean_level <= 10'h000;
      computed_integration <= `STATUS_RESET;
      computed_mux_gain <= 2'h0;
      computed_afe_gain <= 2'h0;
      computed_digital_gain <= 12'h000;
    end else if (aec_request) begin
      stats_pixel_count <= aec_pixel_count;
      frame_mean_level <= aec_mean_level;
      computed_integration <= aec_integration;
      computed_mux_gain <= aec_mux_gain;
      computed_afe_gain <= aec_afe_gain;
      computed_digital_gain <= aec_digital_gain;
    end
  end

  // Sequencer words latch only when values take effect, hence they trail
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      applied_step_granularity <= `STATUS_RESET;
      applied_array_clear_span <= `STATUS_RESET;
      applied_integration <= `STATUS_RESET;
      applied_second_knee_time <= `STATUS_RESET;
      applied_third_knee_time <= `STATUS_RESET;
      applied_mux_gain <= 5'h00;
      applied_afe_gain <= 8'h00;
      applied_fine_gain <= 12'h000;
      applied_dual_slope <= 1'b0;
      applied_triple_slope <= 1'b0;
    end else if (seq_apply) begin
      applied_step_granularity <= seq_step_granularity;
      applied_array_clear_span <= seq_clear_span;
      applied_integration <= seq_integration;
      applied_second_knee_time <= seq_second_knee_time;
      applied_third_knee_time <= seq_third_knee_time;
      applied_mux_gain <= seq_mux_gain;
      applied_afe_gain <= seq_afe_gain;
      applied_fine_gain <= seq_fine_gain;
      applied_dual_slope <= seq_dual_slope;
      applied_triple_slope <= seq_triple_slope;
    end
  end

  // Only the two configuration words accept writes; status words ignore them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      monitor_sel <= exposure_status_pkg::monitor_sel_t'(`MONITOR_SEL_RESET);
    end else if (write_hit(reg_wr, reg_addr, `OFS_MONITOR_CONFIG)) begin
      monitor_sel <= exposure_status_pkg::monitor_sel_t'(
        reg_wdata[`MONITOR_SEL_MSB:`MONITOR_SEL_LSB]);
    end
  end

  // Probe enable, off after reset to save power until software wants it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      thermal_probe_on <= `THERMAL_PROBE_ON_RESET;
    end else if (write_hit(reg_wr, reg_addr, `OFS_THERMAL_PROBE_ON)) begin
      thermal_probe_on <= reg_wdata[0];
    end
  end

  // Read answer one cycle after the strobe; unmapped indices read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= `STATUS_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_STATS_PIXEL_COUNT: reg_rdata <= stats_pixel_count;
        `OFS_FRAME_MEAN_LEVEL: reg_rdata <= {6'h00, frame_mean_level};
        `OFS_COMPUTED_INTEGRATION: reg_rdata <= computed_integration;
        `OFS_COMPUTED_GAINS: begin
          reg_rdata <= {computed_digital_gain, computed_afe_gain,
                        computed_mux_gain};
        end
        `OFS_APPLIED_STEP_GRANULARITY: reg_rdata <= applied_step_granularity;
        `OFS_APPLIED_ARRAY_CLEAR_SPAN: reg_rdata <= applied_array_clear_span;
        `OFS_APPLIED_INTEGRATION: reg_rdata <= applied_integration;
        `OFS_APPLIED_SECOND_KNEE_TIME: reg_rdata <= applied_second_knee_time;
        `OFS_APPLIED_THIRD_KNEE_TIME: reg_rdata <= applied_third_knee_time;
        `OFS_APPLIED_ANALOG_GAINS: begin
          reg_rdata <= {3'h0, applied_afe_gain, applied_mux_gain};
        end
        `OFS_APPLIED_FINE_GAIN_AND_KNEES: begin
          reg_rdata <= {2'h0, applied_triple_slope, applied_dual_slope,
                        applied_fine_gain};
        end
        `OFS_MONITOR_CONFIG: reg_rdata <= {2'h0, monitor_sel, 11'h000};
        `OFS_JUNCTION_TEMP_COUNT: reg_rdata <= {8'h00, junction_temp_count};
        `OFS_THERMAL_PROBE_ON: reg_rdata <= {15'h0000, thermal_probe_on};
        default: reg_rdata <= `STATUS_RESET;
      endcase
    end
  end

  // Valid pulse marks the cycle in which read data is fresh
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // Temperature sensor run and reset control
  thermal_probe_ctl u_probe (
    .clk(clk),
    .reset(reset),
    .probe_on(thermal_probe_on),
    .temp_code(temp_code),
    .temp_code_valid(temp_code_valid),
    .temp_sensor_enable(temp_sensor_enable),
    .temp_sensor_reset_n(temp_sensor_reset_n),
    .junction_temp_count(junction_temp_count)
  );

  // Monitor pin routing
  monitor_route u_monitor (
    .clk(clk),
    .reset(reset),
    .sel(monitor_sel),
    .integration_time(integration_time),
    .row_overhead_time(row_overhead_time),
    .row_overhead_start(row_overhead_start),
    .knee_sequence(knee_sequence),
    .xro_start(xro_start),
    .black_line(black_line),
    .frame_start(frame_start),
    .first_line(first_line),
    .xro_black_start(xro_black_start),
    .xro_image_start(xro_image_start),
    .monitor0(monitor0),
    .monitor1(monitor1)
  );

  // Read request and its answer
  sequence s_read_pixels;
    reg_rd && reg_addr == `OFS_STATS_PIXEL_COUNT;
  endsequence
  sequence s_read_mean;
    reg_rd && reg_addr == `OFS_FRAME_MEAN_LEVEL;
  endsequence

  a_aec_refresh: assert property (@(posedge clk) disable iff (reset)
    aec_request |=> computed_integration == $past(aec_integration)
      && stats_pixel_count == $past(aec_pixel_count))
    else $error("controller words not refreshed on request");

  a_aec_hold_words: assert property (@(posedge clk) disable iff (reset)
    !aec_request |=> $stable(computed_digital_gain) && $stable(computed_mux_gain)
      && $stable(frame_mean_level))
    else $error("controller words changed without request");

  a_seq_refresh: assert property (@(posedge clk) disable iff (reset)
    seq_apply |=> applied_integration == $past(seq_integration)
      && applied_array_clear_span == $past(seq_clear_span))
    else $error("sequencer words not refreshed on apply");

  a_seq_hold_words: assert property (@(posedge clk) disable iff (reset)
    !seq_apply |=> $stable(applied_integration) && $stable(applied_step_granularity))
    else $error("sequencer words changed without apply");

  a_pixel_read: assert property (@(posedge clk) disable iff (reset)
    s_read_pixels |=> reg_rvalid && reg_rdata == $past(stats_pixel_count))
    else $error("pixel count read wrong");

  a_mean_width: assert property (@(posedge clk) disable iff (reset)
    s_read_mean |=> reg_rvalid && reg_rdata[15:10] == 6'h00)
    else $error("mean level upper bits not zero");

  a_gain_pack: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == `OFS_APPLIED_ANALOG_GAINS && !seq_apply
      |=> reg_rdata == {3'h0, applied_afe_gain, applied_mux_gain})
    else $error("analog gain word packed wrong");

  a_knee_flags: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == `OFS_APPLIED_FINE_GAIN_AND_KNEES && !seq_apply
      |=> reg_rdata[13:12] == {applied_triple_slope, applied_dual_slope})
    else $error("slope flags read wrong");

  a_ro_write_ignored: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == `OFS_COMPUTED_INTEGRATION && !aec_request
      |=> $stable(computed_integration))
    else $error("status word changed by a write");

  a_temp_read: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == `OFS_JUNCTION_TEMP_COUNT
      |=> reg_rdata == {8'h00, $past(junction_temp_count)})
    else $error("temperature count read wrong");

endmodule : exposure_status_and_temp_readout

// ==== reg_host.sv ====
// Purpose: Host model that reads and writes the block's registers
// Assumes: One-cycle strobes, read data returned with a one-cycle valid pulse
// Notes: Address and data are inverted when idle so stale values never look valid
`timescale 1ns/1ps

module reg_host (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [8:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata
);
  // Idle bus at time zero
  initial begin
    reg_addr = 9'h1ff;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  // One write strobe, then the bus is scrambled
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // One read strobe; data taken while the valid pulse stands, bounded wait
  task automatic rd(input logic [8:0] a, output logic [15:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 4 && ok !== 1'b1; n++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask : rd
endmodule : reg_host

// ==== test_exposure_status_and_temp_readout.sv ====
// Purpose: Self-checking bench for the exposure status and temperature block
// Assumes: Host model drives the register path, bench drives everything else
// Notes: Status reads run from a table, awkward cases are written by hand
`timescale 1ns/1ps
`include "exposure_status_consts.svh"

module test_exposure_status_and_temp_readout;
  logic clk, reset, reg_wr, reg_rd, reg_rvalid; // Clock, reset and host strobes
  logic [8:0] reg_addr; // Host index
  logic [15:0] reg_wdata, reg_rdata; // Host data
  logic aec_request, seq_apply, temp_code_valid; // Handoff pulses
  logic [15:0] aec_pixel_count, aec_integration, seq_step_granularity, seq_clear_span;
  logic [15:0] seq_integration, seq_second_knee_time, seq_third_knee_time;
  logic [9:0] aec_mean_level; // Mean level input
  logic [1:0] aec_mux_gain, aec_afe_gain; // Computed analog gains
  logic [11:0] aec_digital_gain, seq_fine_gain; // Fine gains
  logic [4:0] seq_mux_gain; // Applied first stage
  logic [7:0] seq_afe_gain, temp_code; // Applied second stage, converter count
  logic seq_dual_slope, seq_triple_slope; // Knee flags
  logic temp_sensor_enable, temp_sensor_reset_n, monitor0, monitor1; // Outputs
  logic [9:0] st; // All sequencer states, one bit each
  wire integration_time = st[0], row_overhead_time = st[1], row_overhead_start = st[2];
  wire knee_sequence = st[3], xro_start = st[4], black_line = st[5], frame_start = st[6];
  wire first_line = st[7], xro_black_start = st[8], xro_image_start = st[9];
  int err_count = 0; // Mismatches
  int samples_checked = 0; // Comparisons
  logic [24:0] rows [12]; // Index beside expected word
  logic [10:0] ex; // States plus a constant zero at bit 10
  localparam int SRC0 [8] = '{10, 0, 0, 4, 6, 7, 1, 8}; // Source of monitor0 per code
  localparam int SRC1 [8] = '{10, 1, 3, 5, 2, 2, 4, 9}; // Source of monitor1 per code
  localparam logic [9:0] PATS [4] = '{10'h155, 10'h2aa, 10'h333, 10'h0f0};

  exposure_status_and_temp_readout uut (.clk, .reset, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .aec_request, .aec_pixel_count, .aec_mean_level,
    .aec_integration, .aec_mux_gain, .aec_afe_gain, .aec_digital_gain, .seq_apply,
    .seq_step_granularity, .seq_clear_span, .seq_integration, .seq_second_knee_time,
    .seq_third_knee_time, .seq_mux_gain, .seq_afe_gain, .seq_fine_gain, .seq_dual_slope,
    .seq_triple_slope, .temp_code, .temp_code_valid, .temp_sensor_enable,
    .temp_sensor_reset_n, .integration_time, .row_overhead_time, .row_overhead_start,
    .knee_sequence, .xro_start, .black_line, .frame_start, .first_line, .xro_black_start,
    .xro_image_start, .monitor0, .monitor1);

  reg_host host (.clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run, shared by the watchdog
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // One comparison, counted
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // Read one register and compare; a missing answer is a mismatch too
  task automatic rchk(input logic [8:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    host.rd(a, d, ok);
    chk($sformatf("answer %h", a), 16'h0001, {15'h0, ok});
    chk($sformatf("reg %h", a), e, d);
  endtask : rchk

  // One-cycle pulse: 0 controller handoff, 1 applied, 2 converter count
  task automatic pulse(input int k);
    @(posedge clk);
    #1;
    aec_request = (k == 0);
    seq_apply = (k == 1);
    temp_code_valid = (k == 2);
    @(posedge clk);
    #1;
    aec_request = 1'b0;
    seq_apply = 1'b0;
    temp_code_valid = 1'b0;
  endtask : pulse

  // Watchdog: the tests need well under two thousand cycles
  initial begin
    #50000;
    err_count++;
    close_out();
  end

  // Main sequence
  initial begin
    {aec_request, seq_apply, temp_code_valid, seq_dual_slope, seq_triple_slope} = 5'h00;
    {aec_pixel_count, aec_integration, aec_mean_level, aec_digital_gain} = 54'h0;
    {aec_mux_gain, aec_afe_gain, seq_mux_gain, seq_afe_gain, temp_code} = 25'h0;
    {seq_step_granularity, seq_clear_span, seq_integration} = 48'h0;
    {seq_second_knee_time, seq_third_knee_time, seq_fine_gain} = 44'h0;
    st = 10'h3ff;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk("reset outputs", 16'h0000, {12'h0, monitor0, monitor1, temp_sensor_enable, reg_rvalid});
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    rchk(`OFS_COMPUTED_INTEGRATION, `STATUS_RESET);
    rchk(`OFS_MONITOR_CONFIG, 16'h0000);
    rchk(`OFS_THERMAL_PROBE_ON, 16'h0000);
    $display("test reset done");
    aec_pixel_count = 16'h1234;
    aec_mean_level = 10'h3a5;
    aec_integration = 16'habcd;
    {aec_digital_gain, aec_afe_gain, aec_mux_gain} = {12'hf81, 2'h3, 2'h1};
    {seq_step_granularity, seq_clear_span, seq_integration} = 48'h1111_2222_3333;
    {seq_second_knee_time, seq_third_knee_time} = 32'h4444_5555;
    {seq_afe_gain, seq_mux_gain, seq_fine_gain} = {8'hc3, 5'h1f, 12'h7e9};
    {seq_triple_slope, seq_dual_slope} = 2'b01;
    pulse(0);
    pulse(1);
    rows = '{{`OFS_STATS_PIXEL_COUNT, 16'h1234}, {`OFS_FRAME_MEAN_LEVEL, 6'h0, 10'h3a5},
      {`OFS_COMPUTED_INTEGRATION, 16'habcd}, {`OFS_COMPUTED_GAINS, 12'hf81, 2'h3, 2'h1},
      {`OFS_APPLIED_STEP_GRANULARITY, 16'h1111}, {`OFS_APPLIED_ARRAY_CLEAR_SPAN, 16'h2222},
      {`OFS_APPLIED_INTEGRATION, 16'h3333}, {`OFS_APPLIED_SECOND_KNEE_TIME, 16'h4444},
      {`OFS_APPLIED_THIRD_KNEE_TIME, 16'h5555}, {`OFS_APPLIED_ANALOG_GAINS, 3'h0, 8'hc3, 5'h1f},
      {`OFS_APPLIED_FINE_GAIN_AND_KNEES, 2'h0, 2'b01, 12'h7e9}, {9'h0b9, 16'h0000}};
    foreach (rows[i]) rchk(rows[i][24:16], rows[i][15:0]);
    $display("test status table done");
    aec_integration = 16'h0f0f;
    seq_integration = 16'h7777;
    pulse(0);
    rchk(`OFS_COMPUTED_INTEGRATION, 16'h0f0f);
    rchk(`OFS_APPLIED_INTEGRATION, 16'h3333);
    pulse(1);
    rchk(`OFS_APPLIED_INTEGRATION, 16'h7777);
    $display("test lag done");
    host.wr(`OFS_COMPUTED_INTEGRATION, 16'hffff);
    host.wr(`OFS_APPLIED_FINE_GAIN_AND_KNEES, 16'h0000);
    host.wr(`OFS_JUNCTION_TEMP_COUNT, 16'h00aa);
    rchk(`OFS_COMPUTED_INTEGRATION, 16'h0f0f);
    rchk(`OFS_APPLIED_FINE_GAIN_AND_KNEES, 16'h17e9);
    rchk(`OFS_JUNCTION_TEMP_COUNT, 16'h0000);
    $display("test read only done");
    temp_code = 8'h5a;
    pulse(2);
    rchk(`OFS_JUNCTION_TEMP_COUNT, 16'h0000);
    host.wr(`OFS_THERMAL_PROBE_ON, 16'h0001);
    repeat (2) @(posedge clk);
    #1;
    chk("sensor run", 16'h0003, {14'h0, temp_sensor_enable, temp_sensor_reset_n});
    temp_code = 8'hff;
    pulse(2);
    rchk(`OFS_JUNCTION_TEMP_COUNT, 16'h00ff);
    rchk(`OFS_THERMAL_PROBE_ON, 16'h0001);
    host.wr(`OFS_THERMAL_PROBE_ON, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk("sensor off", 16'h0000, {14'h0, temp_sensor_enable, temp_sensor_reset_n});
    rchk(`OFS_JUNCTION_TEMP_COUNT, 16'h0000);
    $display("test temperature done");
    for (int c = 0; c < 8; c++) begin
      host.wr(`OFS_MONITOR_CONFIG, 16'(c) << `MONITOR_SEL_LSB);
      rchk(`OFS_MONITOR_CONFIG, 16'(c) << `MONITOR_SEL_LSB);
      for (int p = 0; p < 4; p++) begin
        st = PATS[p];
        ex = {1'b0, PATS[p]};
        @(posedge clk);
        #1;
        chk("monitor0", {15'h0, ex[SRC0[c]]}, {15'h0, monitor0});
        chk("monitor1", {15'h0, ex[SRC1[c]]}, {15'h0, monitor1});
      end
    end
    $display("test monitors done");
    reset = 1'b1; // Mid-run reset must clear status words and configuration
    @(posedge clk);
    #1;
    reset = 1'b0;
    chk("monitors after reset", 16'h0000, {14'h0, monitor0, monitor1});
    rchk(`OFS_APPLIED_FINE_GAIN_AND_KNEES, `STATUS_RESET);
    rchk(`OFS_MONITOR_CONFIG, 16'h0000);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : test_exposure_status_and_temp_readout
